// file: nvm_access_map.vh
// Constants for the nonvolatile access and write-protect block.
`ifndef NVM_ACCESS_MAP_VH
`define NVM_ACCESS_MAP_VH

// Array geometry.
`define NVM_BYTES           1024
`define NVM_LAST_ADDR       10'h3ff
`define REG_LAST_ADDR       8'hff
`define PAGE_LAST_OFFSET    4'hf
`define BLOCK_MSB           9
`define BLOCK_LSB           6
`define PAGE_MSB            9
`define PAGE_LSB            4

// Register offsets within the 256-entry register space.
`define BLOCK_PROTECT_LOW   8'h0c
`define BLOCK_PROTECT_HIGH  8'h0d
`define DEVICE_CONFIG_REG   8'h30
`define ERROR_STATUS_REG    8'h34

// Field positions.
`define CFG_OVERRIDE_BIT    2
`define ERR_WP_BLOCKED_BIT  6
`define ERR_CLR_DENIED_BIT  5

// Reset values.
`define BLOCK_PROTECT_RESET 8'h00
`define ERROR_STATUS_RESET  8'h00
`define DEVICE_CONFIG_RESET 8'h00

// Strap sampling: edges after reset before the synchroniser holds settled data.
`define STRAP_FILL_CYCLES   2'h3

`endif

// file: nvm_access_write_protect.v
// Address handling, page-bounded writes and block write protection for the array.
`timescale 1ns/1ps
`include "nvm_access_map.vh"

module nvm_access_write_protect (
    input  wire       clk_in,
    input  wire       resetn_in,
    input  wire       clk_en_in,
    input  wire       strap_direct_in,
    input  wire       start_in,
    input  wire       space_select_in,
    input  wire [9:0] addr_in,
    input  wire       wr_in,
    input  wire [7:0] wr_data_in,
    input  wire       rd_in,
    input  wire       stop_in,
    output reg  [7:0] rd_data_out,
    output reg        rd_valid_out,
    output reg        rd_end_out,
    output reg  [7:0] error_status_out,
    output reg  [7:0] device_config_out,
    output reg [15:0] block_protect_out,
    output reg        tester_mode_out
);

    // A protocol engine on this clock opens a transfer with a start pulse, then
    // gives at most one read or write strobe per cycle and ends with a stop pulse.
    // Reads answer one cycle after their strobe; writes give no answer. The
    // pointer moves on every strobe before the last entry, whether or not the byte lands.
    // Transfer states, one-hot.
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_XFER = 3'b010;
    localparam [2:0] ST_DONE = 3'b100;

    // Array storage as flip-flops; contents are not reset, like a real array.
    // Flip-flop storage is costly in area but needs no memory macro timing.
    reg  [7:0] nvm_mem [0:`NVM_BYTES-1];

    reg  [2:0] state_q;
    reg  [2:0] state_d;
    reg  [9:0] ptr_q;
    reg  [9:0] ptr_d;
    reg        space_q;
    reg  [5:0] page_q;
    reg        page_done_q;
    reg        page_done_d;
    reg  [7:0] protect_lo_q;
    reg  [7:0] protect_hi_q;
    reg  [7:0] protect_lo_d;
    reg  [7:0] protect_hi_d;
    reg  [7:0] err_q;
    reg  [7:0] err_d;
    reg        strap_s1_q;
    reg        strap_s2_q;
    reg        strap_s3_q;
    reg  [1:0] strap_fill_q;
    reg        strap_taken_q;
    reg        override_q;

    // Decoded helpers.
    // The block index is taken from the live pointer, so each byte of a burst
    // is checked against its own block.
    wire [15:0] protect_map;
    wire  [3:0] block_idx;
    wire        block_locked;
    wire        at_last;
    wire        in_page;
    wire        nvm_we;
    wire  [7:0] reg_addr;
    wire  [7:0] cfg_value;
    reg   [7:0] reg_rd_data;

    assign protect_map  = {protect_hi_q, protect_lo_q};
    assign block_idx    = ptr_q[`BLOCK_MSB:`BLOCK_LSB];
    assign block_locked = protect_map[block_idx];
    assign reg_addr     = ptr_q[7:0];

    // The last readable byte differs between the two spaces.
    // Register space looks only at the low eight pointer bits.
    assign at_last = space_q ? (ptr_q == `NVM_LAST_ADDR)
                             : (reg_addr == `REG_LAST_ADDR);

    // A write may land only while the pointer is still in the opening page.
    assign in_page = !page_done_q
                     && (ptr_q[`PAGE_MSB:`PAGE_LSB] == page_q);

    // Overrun and protected bytes still move the pointer; only the store is held
    // back, so the engine needs no knowledge of page or block limits.
    assign nvm_we = clk_en_in && wr_in && (state_q == ST_XFER) && space_q
                    && in_page && !block_locked;

    // Configuration image: only the override bit can ever be set.
    assign cfg_value = `DEVICE_CONFIG_RESET
                       | ({7'h00, override_q} << `CFG_OVERRIDE_BIT);

    // Register space read mux; unimplemented entries read as zero.
    // Protect entries show the stored map, not a write pending in this cycle.
    always @* begin
        case (reg_addr)
            `BLOCK_PROTECT_LOW:  reg_rd_data = protect_lo_q;
            `BLOCK_PROTECT_HIGH: reg_rd_data = protect_hi_q;
            `DEVICE_CONFIG_REG:  reg_rd_data = device_config_out;
            `ERROR_STATUS_REG:   reg_rd_data = err_q;
            default:             reg_rd_data = 8'h00;
        endcase
    end

    // Strap synchroniser: three flops, the first feeds only the second.
    // The strap is a static pin, so the extra flop costs nothing in response.
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
            strap_s3_q <= 1'b0;
        end else if (clk_en_in) begin
            strap_s1_q <= strap_direct_in;
            strap_s2_q <= strap_s1_q;
            strap_s3_q <= strap_s2_q;
        end
    end

    // The strap is caught once after reset, when the pipe is full and settled.
    // Catching it only once keeps the mode fixed even if the pin glitches later.
    // Capturing before the pipe fills would take the reset zeros as the pin level.
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            strap_fill_q  <= 2'h0;
            strap_taken_q <= 1'b0;
            override_q    <= 1'b0;
        end else if (clk_en_in) begin
            if (strap_fill_q != `STRAP_FILL_CYCLES) begin
                strap_fill_q <= strap_fill_q + 2'h1;
            end else if (!strap_taken_q && (strap_s2_q == strap_s3_q)) begin
                strap_taken_q <= 1'b1;
                override_q    <= strap_s3_q;
            end
        end
    end

    // Protect register writes and error flag updates.
    // In run-time mode the new map is the old map ORed with the data, so a write
    // can only set bits; a refused clear is flagged further down.
    always @* begin
        protect_lo_d = protect_lo_q;
        protect_hi_d = protect_hi_q;
        err_d        = err_q;
        if (wr_in && (state_q == ST_XFER) && !space_q) begin
            case (reg_addr)
                `BLOCK_PROTECT_LOW: begin
                    if (override_q) begin
                        protect_lo_d = wr_data_in;
                    end else begin
                        protect_lo_d = protect_lo_q | wr_data_in;
                    end
                end
                `BLOCK_PROTECT_HIGH: begin
                    if (override_q) begin
                        protect_hi_d = wr_data_in;
                    end else begin
                        protect_hi_d = protect_hi_q | wr_data_in;
                    end
                end
                `ERROR_STATUS_REG: begin
                    // Software clears error flags by writing ones.
                    err_d = err_q & ~wr_data_in;
                end
                default: begin
                    err_d = err_q;
                end
            endcase
        end
        // Hardware sets are applied last so that a set beats a clear.
        // A write that sets one bit and clears another does both: set and flag.
        if (wr_in && (state_q == ST_XFER) && !space_q && !override_q) begin
            if ((reg_addr == `BLOCK_PROTECT_LOW) && ((protect_lo_q & ~wr_data_in) != 8'h00)) begin
                err_d[`ERR_CLR_DENIED_BIT] = 1'b1;
            end
            if ((reg_addr == `BLOCK_PROTECT_HIGH) && ((protect_hi_q & ~wr_data_in) != 8'h00)) begin
                err_d[`ERR_CLR_DENIED_BIT] = 1'b1;
            end
        end
        // Only a write that would have landed counts as blocked; overrun
        // bytes are dropped silently.
        if (wr_in && (state_q == ST_XFER) && space_q && in_page && block_locked) begin
            err_d[`ERR_WP_BLOCKED_BIT] = 1'b1;
        end
    end

    // Pointer and transfer sequencing.
    // The pointer halts at the last entry instead of rolling over, so a long read
    // cannot alias back to entry zero.
    always @* begin
        state_d     = state_q;
        ptr_d       = ptr_q;
        page_done_d = page_done_q;
        case (state_q)
            ST_IDLE: begin
                state_d = ST_IDLE;
            end
            ST_XFER: begin
                if (rd_in || wr_in) begin
                    if (at_last) begin
                        state_d = ST_DONE;
                    end else begin
                        ptr_d = ptr_q + 10'h001;
                    end
                end
                // The page closes on its last offset, so low bits that roll over
                // cannot reopen it.
                if (wr_in && space_q
                    && (ptr_q[`PAGE_LSB-1:0] == `PAGE_LAST_OFFSET)) begin
                    page_done_d = 1'b1;
                end
            end
            ST_DONE: begin
                // Strobes are refused here until a stop or a new start.
                state_d = ST_DONE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // A stop ends any transfer; a start opens a new one and wins.
        if (stop_in) begin
            state_d = ST_IDLE;
        end
        if (start_in) begin
            state_d     = ST_XFER;
            page_done_d = 1'b0;
            if (space_select_in) begin
                ptr_d = addr_in;
            end else begin
                ptr_d = {2'b00, addr_in[7:0]};
            end
        end
    end

    // Sequential state.
    // A low clock enable freezes the pointer, the map and the flags alike.
    // The opening page is latched at start so later bytes can be held to it.
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            state_q      <= ST_IDLE;
            ptr_q        <= 10'h000;
            space_q      <= 1'b0;
            page_q       <= 6'h00;
            page_done_q  <= 1'b0;
            protect_lo_q <= `BLOCK_PROTECT_RESET;
            protect_hi_q <= `BLOCK_PROTECT_RESET;
            err_q        <= `ERROR_STATUS_RESET;
        end else if (clk_en_in) begin
            state_q      <= state_d;
            ptr_q        <= ptr_d;
            page_done_q  <= page_done_d;
            protect_lo_q <= protect_lo_d;
            protect_hi_q <= protect_hi_d;
            err_q        <= err_d;
            if (start_in) begin
                space_q <= space_select_in;
                page_q  <= addr_in[`PAGE_MSB:`PAGE_LSB];
            end
        end
    end

    // Array write port; the pointer never wraps, so no byte lands twice.
    always @(posedge clk_in) begin
        if (nvm_we) begin
            nvm_mem[ptr_q] <= wr_data_in;
        end
    end

    // Read answers: data one cycle after the strobe, or an end marker.
    // The end marker tells the engine that the space is exhausted and a stop is due.
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            rd_data_out  <= 8'h00;
            rd_valid_out <= 1'b0;
            rd_end_out   <= 1'b0;
        end else if (clk_en_in) begin
            rd_valid_out <= 1'b0;
            rd_end_out   <= 1'b0;
            if (rd_in && (state_q == ST_XFER)) begin
                rd_valid_out <= 1'b1;
                rd_data_out  <= space_q ? nvm_mem[ptr_q] : reg_rd_data;
            end else if (rd_in && (state_q == ST_DONE)) begin
                rd_end_out <= 1'b1;
            end
        end
    end

    // Error and protect outputs take the next-state values, so they change on the same edge
    // as the registers they show; config and mode outputs follow override_q a cycle behind.
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            error_status_out  <= `ERROR_STATUS_RESET;
            device_config_out <= `DEVICE_CONFIG_RESET;
            block_protect_out <= {`BLOCK_PROTECT_RESET, `BLOCK_PROTECT_RESET};
            tester_mode_out   <= 1'b0;
        end else if (clk_en_in) begin
            error_status_out  <= err_d;
            device_config_out <= cfg_value;
            block_protect_out <= {protect_hi_d, protect_lo_d};
            tester_mode_out   <= override_q;
        end
    end

endmodule

// file: nvm_access_write_protect_chk.sv
// Port assertions for the nonvolatile access and write-protect block.
`timescale 1ns/1ps
module nvm_access_write_protect_chk (
    input wire        clk_in,
    input wire        resetn_in,
    input wire        clk_en_in,
    input wire        wr_in,
    input wire        rd_in,
    input wire        rd_valid_out,
    input wire        rd_end_out,
    input wire [7:0]  error_status_out,
    input wire [7:0]  device_config_out,
    input wire [15:0] block_protect_out,
    input wire        tester_mode_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    // Every read answer is caused by a read request one enabled edge earlier.
    property p_rd_cause;
        (rd_valid_out || rd_end_out) && $past(clk_en_in) |-> $past(rd_in);
    endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("read answer without request");
    // A read either returns data or reports the end, never both.
    property p_rd_excl;
        !(rd_valid_out && rd_end_out);
    endproperty
    a_rd_excl: assert property (p_rd_excl) else $error("data and end together");
    // Only the override bit of the configuration may ever be set.
    property p_cfg_bits;
        (device_config_out & 8'hfb) == 8'h00;
    endproperty
    a_cfg_bits: assert property (p_cfg_bits) else $error("stray config bit");
    // The mode flag mirrors the override bit.
    property p_mode_copy;
        tester_mode_out == device_config_out[2];
    endproperty
    a_mode_copy: assert property (p_mode_copy) else $error("mode flag mismatch");
    // In run-time mode a protect bit never falls.
    property p_sticky;
        !tester_mode_out && $past(!tester_mode_out)
            |-> ($past(block_protect_out) & ~block_protect_out) == 16'h0000;
    endproperty
    a_sticky: assert property (p_sticky) else $error("protect bit cleared");
    // The protect map only moves one edge after a write.
    property p_map_cause;
        block_protect_out != $past(block_protect_out) |-> $past(wr_in);
    endproperty
    a_map_cause: assert property (p_map_cause) else $error("map moved without write");
    // A blocked-write flag rises only after a write.
    property p_err6_cause;
        $rose(error_status_out[6]) |-> $past(wr_in);
    endproperty
    a_err6_cause: assert property (p_err6_cause) else $error("bit 6 without write");
    // Overrun drops leave no trace: only the two error bits exist.
    property p_err_bits;
        (error_status_out & 8'h9f) == 8'h00;
    endproperty
    a_err_bits: assert property (p_err_bits) else $error("stray status bit");
endmodule

bind nvm_access_write_protect nvm_access_write_protect_chk u_chk (.clk_in, .resetn_in,
    .clk_en_in, .wr_in, .rd_in, .rd_valid_out, .rd_end_out, .error_status_out,
    .device_config_out, .block_protect_out, .tester_mode_out);

// file: host_port_model.sv
// Host-side engine model that drives the transfer port of the block.
`timescale 1ns/1ps
module host_port_model (
    input  wire       clk_in,
    input  wire       rd_valid_in,
    input  wire       rd_end_in,
    input  wire [7:0] rd_data_in,
    output reg        start_out,
    output reg        space_out,
    output reg  [9:0] addr_out,
    output reg        wr_out,
    output reg  [7:0] wr_data_out,
    output reg        rd_out,
    output reg        stop_out
);
    // Every request line starts idle, before the first falling edge.
    initial begin
        start_out = 1'b0;
        space_out = 1'b0;
        addr_out = 10'h000;
        wr_out = 1'b0;
        wr_data_out = 8'h00;
        rd_out = 1'b0;
        stop_out = 1'b0;
    end
    // Requests change on falling edges so the block samples settled values.
    task automatic open(input logic sp, input logic [9:0] a);
        @(negedge clk_in);
        start_out <= 1'b1;
        space_out <= sp;
        addr_out <= a;
        @(negedge clk_in);
        start_out <= 1'b0;
    endtask
    // Writes stay high across calls, so bursts are back to back.
    task automatic put(input logic [7:0] x);
        @(negedge clk_in);
        wr_out <= 1'b1;
        wr_data_out <= x;
    endtask
    // The answer stands only for the cycle after the strobe edge, so it is
    // taken at the next falling edge, before it drops again.
    task automatic get(output logic v, output logic e, output logic [7:0] x);
        @(negedge clk_in);
        wr_out <= 1'b0;
        rd_out <= 1'b1;
        @(negedge clk_in);
        v = rd_valid_in;
        e = rd_end_in;
        x = rd_data_in;
        rd_out <= 1'b0;
    endtask
    // Every transfer ends with a stop; the released data bus is scrambled.
    task automatic close;
        @(negedge clk_in);
        wr_out <= 1'b0;
        wr_data_out <= ~wr_data_out;
        stop_out <= 1'b1;
        @(negedge clk_in);
        stop_out <= 1'b0;
    endtask
endmodule

// file: tb_nvm_access_write_protect.sv
// Self-checking bench for the nonvolatile access and write-protect block.
`timescale 1ns/1ps
module tb_nvm_access_write_protect;
    reg         clk_in = 1'b0;
    reg         resetn_in = 1'b0;
    reg         strap_direct_in = 1'b0;
    reg         clk_en_in = 1'b1;
    wire        start_in, space_select_in, wr_in, rd_in, stop_in;
    wire        rd_valid_out, rd_end_out, tester_mode_out;
    wire [9:0]  addr_in;
    wire [7:0]  wr_data_in, rd_data_out, error_status_out, device_config_out;
    wire [15:0] block_protect_out;
    integer     failures = 0;
    integer     total_checks = 0;
    reg         v, e;
    reg  [7:0]  d;

    // Free-running 100 MHz clock.
    initial forever #5 clk_in = ~clk_in;

    nvm_access_write_protect u_dut (.clk_in, .resetn_in, .clk_en_in, .strap_direct_in,
        .start_in, .space_select_in, .addr_in, .wr_in, .wr_data_in, .rd_in, .stop_in,
        .rd_data_out, .rd_valid_out, .rd_end_out, .error_status_out, .device_config_out,
        .block_protect_out, .tester_mode_out);
    host_port_model u_host (.clk_in, .rd_valid_in(rd_valid_out), .rd_end_in(rd_end_out),
        .rd_data_in(rd_data_out), .start_out(start_in), .space_out(space_select_in),
        .addr_out(addr_in), .wr_out(wr_in), .wr_data_out(wr_data_in), .rd_out(rd_in),
        .stop_out(stop_in));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // A read either carries the expected byte or, with ok low, reports the end.
    task automatic rd_exp(input logic ok, input logic [7:0] x);
        u_host.get(v, e, d);
        chk({6'h00, v, e, ok ? d : 8'h00}, {6'h00, ok, !ok, x});
    endtask
    task automatic wr1(input logic sp, input logic [9:0] a, input logic [7:0] x);
        u_host.open(sp, a);
        u_host.put(x);
        u_host.close();
    endtask
    // Strap must be steady well before the block captures it after release.
    task automatic do_reset(input logic s);
        @(negedge clk_in);
        strap_direct_in = s;
        resetn_in = 1'b0;
        repeat (2) @(negedge clk_in);
        resetn_in = 1'b1;
        repeat (8) @(negedge clk_in);
    endtask
    task automatic t_reset;
        chk({error_status_out, device_config_out}, 16'h0000);
        chk(block_protect_out, 16'h0000);
        chk({15'h0000, tester_mode_out}, 16'h0000);
    endtask
    // The overrun bytes must neither land past the page nor wrap to its start.
    task automatic t_page;
        wr1(1'b1, 10'h000, 8'h5a);
        wr1(1'b1, 10'h010, 8'ha5);
        u_host.open(1'b1, 10'h00e);
        u_host.put(8'h11);
        u_host.put(8'h22);
        u_host.put(8'h33);
        u_host.put(8'h44);
        u_host.close();
        u_host.open(1'b1, 10'h00e);
        rd_exp(1'b1, 8'h11);
        rd_exp(1'b1, 8'h22);
        rd_exp(1'b1, 8'ha5);
        u_host.close();
        u_host.open(1'b1, 10'h000);
        rd_exp(1'b1, 8'h5a);
        u_host.close();
        chk({8'h00, error_status_out}, 16'h0000);
    endtask
    task automatic t_last;
        u_host.open(1'b1, 10'h3fe);
        u_host.put(8'hc3);
        u_host.put(8'h3c);
        u_host.close();
        u_host.open(1'b1, 10'h3fe);
        rd_exp(1'b1, 8'hc3);
        rd_exp(1'b1, 8'h3c);
        rd_exp(1'b0, 8'h00);
        u_host.close();
    endtask
    // Upper address bits are dropped in register space; only the low eight select the register.
    task automatic t_regs;
        wr1(1'b0, 10'h30c, 8'h01);
        chk(block_protect_out, 16'h0001);
        wr1(1'b0, 10'h00d, 8'h80);
        chk(block_protect_out, 16'h8001);
        u_host.open(1'b0, 10'h0fe);
        rd_exp(1'b1, 8'h00);
        rd_exp(1'b1, 8'h00);
        rd_exp(1'b0, 8'h00);
        u_host.close();
    endtask
    task automatic t_protect;
        wr1(1'b1, 10'h000, 8'h77);
        chk({8'h00, error_status_out}, 16'h0040);
        u_host.open(1'b1, 10'h000);
        rd_exp(1'b1, 8'h5a);
        u_host.close();
        wr1(1'b0, 10'h00c, 8'h00);
        chk(block_protect_out, 16'h8001);
        chk({8'h00, error_status_out}, 16'h0060);
        wr1(1'b0, 10'h034, 8'h60);
        chk({8'h00, error_status_out}, 16'h0000);
    endtask
    // A direct strap opens tester mode, where protect bits can be cleared.
    task automatic t_tester;
        do_reset(1'b1);
        chk({7'h00, tester_mode_out, device_config_out}, 16'h0104);
        wr1(1'b0, 10'h00c, 8'h01);
        wr1(1'b0, 10'h00c, 8'h00);
        chk(block_protect_out, 16'h0000);
        wr1(1'b1, 10'h000, 8'h99);
        u_host.open(1'b1, 10'h000);
        rd_exp(1'b1, 8'h99);
        u_host.close();
    endtask
    // A low enable must hold off every strobe, register and array write alike.
    task automatic t_freeze;
        @(negedge clk_in);
        clk_en_in = 1'b0;
        wr1(1'b0, 10'h00d, 8'hff);
        wr1(1'b1, 10'h000, 8'h66);
        chk(block_protect_out, 16'h0000);
        chk({7'h00, tester_mode_out, device_config_out}, 16'h0104);
        @(negedge clk_in);
        clk_en_in = 1'b1;
        u_host.open(1'b1, 10'h000);
        rd_exp(1'b1, 8'h99);
        u_host.close();
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // A hung run is cut short and counted as a mismatch.
    initial begin
        #500000;
        failures = failures + 1;
        finish_test();
    end
    // Main sequence.
    initial begin
        do_reset(1'b0);
        t_reset();
        t_page();
        t_last();
        t_regs();
        t_protect();
        t_tester();
        t_freeze();
        finish_test();
    end
endmodule
